// ### logic/lin_wake_pkg.sv
// Package: register map, field positions and types for the LIN wake block
package lin_wake_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] MODE0_OFS   = 8'h00; // Channel mode register zero
    localparam logic [7:0] RFC_OFS     = 8'h04; // Response frame control
    localparam logic [7:0] STATUS_OFS  = 8'h08; // Sticky status flags
    localparam logic [7:0] INTCTL_OFS  = 8'h0c; // Low detect int control
    localparam logic [7:0] MIRROR_OFS  = 8'h10; // Shared low detect mirror
    localparam logic [7:0] RXDATA_OFS  = 8'h14; // Last received byte

    // Field positions in mode register zero
    localparam int LDE_BIT      = 0;            // Low detect enable
    localparam int IE_LSB       = 4;            // Interrupt enables, 4 bits
    // Status flag positions (same layout as enables)
    localparam int ST_LD        = 0;            // Low detect flag
    localparam int ST_RXDONE    = 1;            // Response received
    localparam int ST_ERR       = 2;            // Reception error
    localparam int ST_CSUM      = 3;            // Checksum mismatch
    localparam int NFLAG        = 4;            // Number of flags
    localparam int NCHAN        = 4;            // Channels in mirror

    // Reset values
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // Bit timing: cycles per LIN bit (fixed for this build)
    localparam int BIT_CYC      = 16;
    localparam int HALF_CYC     = BIT_CYC / 2;

    // Receiver states
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_FINAL
    } rx_state_t;

    // APB request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// ### logic/lin_wakeup_low_detect.sv
// LIN response receiver with input low detection and aggregated interrupt
// How it works
// - receive bytes until programmed response length
// - error aborts reception, go to final
// - aborted frame skips checksum evaluation
// - low flag on falling edge or enable-while-low
// - flag with enabled bit raises interrupt request
// - no new request while any flag set
// - flags sticky; write zero clears, one ignored
// - mirror bits read channel low flags
module lin_wakeup_low_detect (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire lin_wake_pkg::apb_req_t  apb_req,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    lin_receive_input,
    input  wire logic [3:1]              other_channel_low_flag,
    input  wire logic                    response_start,
    output logic                         lin_irq,
    output logic                         low_detect_flag
);
    // Mode, control and state registers
    logic [7:0]  channel_mode_reg0_q;          // LOW_DETECT_ENABLE and interrupt enables
    logic [3:0]  response_length_field_q;      // Bytes to receive
    logic [3:0]  int_priority_level_q;         // Level (bits 2:0) and pending
    logic [3:0]  flags_q, flags_d;             // Sticky status flags
    logic [7:0]  rx_byte_q;                    // Shift register
    logic [7:0]  rx_last_q;                    // Last full byte
    logic [7:0]  csum_q;                       // Running checksum
    logic [3:0]  byte_cnt_q;                   // Bytes received
    logic [2:0]  bit_cnt_q;                    // Data bit index
    logic [4:0]  tick_q;                       // Bit timer
    logic        lin_prev_q;                   // Previous line level
    logic        abort_q;                      // Frame aborted by error
    logic        irq_q;                        // Registered request
    lin_wake_pkg::rx_state_t state_q;          // Receiver state

    // Bus decode
    wire acc     = apb_req.psel & apb_req.penable;
    // Writes land only at the edge that completes the transfer
    wire wr      = acc & apb_req.pwrite & pready;
    wire wr_mode = wr & (apb_req.paddr == lin_wake_pkg::MODE0_OFS);
    wire wr_rfc  = wr & (apb_req.paddr == lin_wake_pkg::RFC_OFS);
    wire wr_st   = wr & (apb_req.paddr == lin_wake_pkg::STATUS_OFS);
    wire wr_ic   = wr & (apb_req.paddr == lin_wake_pkg::INTCTL_OFS);
    wire mapped  = apb_req.paddr inside {lin_wake_pkg::MODE0_OFS,
        lin_wake_pkg::RFC_OFS, lin_wake_pkg::STATUS_OFS,
        lin_wake_pkg::INTCTL_OFS, lin_wake_pkg::MIRROR_OFS,
        lin_wake_pkg::RXDATA_OFS};
    wire low_detect_enable     = channel_mode_reg0_q[lin_wake_pkg::LDE_BIT];
    wire [3:0] ie = channel_mode_reg0_q[lin_wake_pkg::IE_LSB +: 4];
    // Enables as they stand after this edge, so the irq never lags a write
    wire [3:0] ie_next = wr_mode ? apb_req.pwdata[lin_wake_pkg::IE_LSB +: 4]
                                 : ie;

    // Low detect conditions: edge while enabled, or enable rising while low
    wire fall     = lin_prev_q & ~lin_receive_input;
    wire lde_rise = wr_mode & ~low_detect_enable
                  & apb_req.pwdata[lin_wake_pkg::LDE_BIT];
    wire ld_set   = (low_detect_enable & fall) | (lde_rise & ~lin_receive_input);

    // Receiver timing
    wire tick_mid  = (tick_q == 5'(lin_wake_pkg::HALF_CYC - 1));
    wire tick_end  = (tick_q == 5'(lin_wake_pkg::BIT_CYC - 1));
    wire last_byte = (byte_cnt_q + 4'h1 >= response_length_field_q);
    wire stop_err  = (state_q == lin_wake_pkg::RX_STOP) & tick_mid
                   & ~lin_receive_input;
    wire start_err = (state_q == lin_wake_pkg::RX_START) & tick_mid
                   & lin_receive_input;
    wire rx_err    = stop_err | start_err;
    wire in_final  = (state_q == lin_wake_pkg::RX_FINAL);
    // Checksum: running sum takes the byte just shifted in; the final
    // byte must make the carry-wrapped sum all ones
    wire [8:0] sum9 = {1'b0, csum_q} + {1'b0, rx_byte_q};
    wire csum_bad  = (sum9[7:0] + {7'h00, sum9[8]}) != 8'hff;

    // Flag next value: hardware sets win over software clears
    logic [3:0] hw_set;
    always_comb begin
        hw_set = 4'h0;
        hw_set[lin_wake_pkg::ST_LD]     = ld_set;
        hw_set[lin_wake_pkg::ST_ERR]    = rx_err;
        hw_set[lin_wake_pkg::ST_RXDONE] = in_final & ~abort_q;
        hw_set[lin_wake_pkg::ST_CSUM]   = in_final & ~abort_q
                                        & csum_bad;
        flags_d = flags_q;
        if (wr_st) begin
            flags_d = flags_q & apb_req.pwdata[3:0];
        end
        flags_d = flags_d | hw_set;
    end

    // Aggregated request: only new events when no flag already set
    wire any_flag = |flags_q;
    wire new_req  = |(hw_set & ie) & ~any_flag;

    // Register writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            channel_mode_reg0_q     <= 8'h00;
            response_length_field_q <= 4'h0;
            int_priority_level_q    <= 4'h0;
        end else begin
            if (wr_mode) channel_mode_reg0_q <= apb_req.pwdata[7:0];
            if (wr_rfc) response_length_field_q <= apb_req.pwdata[3:0];
            // Pending bit set by request, software writes may clear it
            if (wr_ic) begin
                int_priority_level_q <= {apb_req.pwdata[3] & ~new_req,
                                         apb_req.pwdata[2:0]};
            end
            if (new_req) int_priority_level_q[3] <= 1'b1;
        end
    end

    // Flags and interrupt output
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flags_q <= 4'h0;
            irq_q   <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q   <= |(flags_d & ie_next);
        end
    end

    // Line history for edge detection
    always_ff @(posedge core_clk) begin
        if (sys_rst) lin_prev_q <= 1'b1;
        else lin_prev_q <= lin_receive_input;
    end

    // Receiver state machine: start bit per byte, count to length
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q    <= lin_wake_pkg::RX_IDLE;
            tick_q     <= 5'h00;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 4'h0;
            rx_byte_q  <= 8'h00;
            rx_last_q  <= 8'h00;
            csum_q     <= 8'h00;
            abort_q    <= 1'b0;
        end else begin
            unique case (state_q)
                lin_wake_pkg::RX_IDLE: begin
                    if (response_start) begin
                        byte_cnt_q <= 4'h0;
                        csum_q     <= 8'h00;
                        abort_q    <= 1'b0;
                        state_q    <= lin_wake_pkg::RX_DATA;
                        tick_q     <= 5'h00;
                        bit_cnt_q  <= 3'h0;
                    end
                end
                lin_wake_pkg::RX_DATA: begin
                    // Wait for start bit, then sample eight data bits
                    if (fall && bit_cnt_q == 3'h0 && tick_q == 5'h00) begin
                        state_q <= lin_wake_pkg::RX_START;
                    end else if (tick_q != 5'h00 || bit_cnt_q != 3'h0) begin
                        tick_q <= tick_end ? 5'h00 : tick_q + 5'h01;
                        if (tick_mid) begin
                            rx_byte_q <= {lin_receive_input, rx_byte_q[7:1]};
                        end
                        if (tick_end) begin
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7) begin
                                state_q <= lin_wake_pkg::RX_STOP;
                            end
                        end
                    end
                end
                lin_wake_pkg::RX_START: begin
                    tick_q <= tick_end ? 5'h00 : tick_q + 5'h01;
                    if (start_err) begin
                        abort_q <= 1'b1;
                        state_q <= lin_wake_pkg::RX_FINAL;
                    end else if (tick_end) begin
                        state_q <= lin_wake_pkg::RX_DATA;
                        tick_q  <= 5'h01;
                    end
                end
                lin_wake_pkg::RX_STOP: begin
                    tick_q <= tick_end ? 5'h00 : tick_q + 5'h01;
                    if (stop_err) begin
                        abort_q <= 1'b1;
                        state_q <= lin_wake_pkg::RX_FINAL;
                    end else if (tick_mid) begin
                        rx_last_q  <= rx_byte_q;
                        byte_cnt_q <= byte_cnt_q + 4'h1;
                        if (!last_byte) csum_q <= sum9[7:0] + {7'h00, sum9[8]};
                        tick_q    <= 5'h00;
                        bit_cnt_q <= 3'h0;
                        state_q   <= last_byte ? lin_wake_pkg::RX_FINAL
                                               : lin_wake_pkg::RX_DATA;
                    end
                end
                lin_wake_pkg::RX_FINAL: begin
                    state_q <= lin_wake_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Read words, one per mapped offset
    wire [31:0] rd_mode   = {24'h0, channel_mode_reg0_q};
    wire [31:0] rd_rfc    = {28'h0, response_length_field_q};
    wire [31:0] rd_status = {28'h0, flags_q};
    wire [31:0] rd_intctl = {28'h0, int_priority_level_q};
    wire [31:0] rd_mirror = {28'h0, other_channel_low_flag,
                             flags_q[lin_wake_pkg::ST_LD]};
    wire [31:0] rd_rxdata = {24'h0, rx_last_q};
    // Read mux; unmapped offsets read as zero
    wire [31:0] rd_mux =
        (apb_req.paddr == lin_wake_pkg::MODE0_OFS)  ? rd_mode   :
        (apb_req.paddr == lin_wake_pkg::RFC_OFS)    ? rd_rfc    :
        (apb_req.paddr == lin_wake_pkg::STATUS_OFS) ? rd_status :
        (apb_req.paddr == lin_wake_pkg::INTCTL_OFS) ? rd_intctl :
        (apb_req.paddr == lin_wake_pkg::MIRROR_OFS) ? rd_mirror :
        (apb_req.paddr == lin_wake_pkg::RXDATA_OFS) ? rd_rxdata :
        lin_wake_pkg::ZERO_RST;

    // APB answer: one wait state, registered outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_req.psel & apb_req.penable & ~pready;
            pslverr <= apb_req.psel & apb_req.penable & ~pready & ~mapped;
            prdata  <= rd_mux;
        end
    end

    assign lin_irq         = irq_q;
    assign low_detect_flag = flags_q[lin_wake_pkg::ST_LD];

    // Assertions: one clock domain, so clock and reset are given once
    default clocking ck @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // Falling edge on the line while detection is enabled
    sequence ld_cause_s;
        low_detect_enable && lin_prev_q && !lin_receive_input;
    endsequence
    // Byte accepted at mid stop bit with more bytes still due
    sequence more_bytes_s;
        state_q == lin_wake_pkg::RX_STOP && tick_mid && !stop_err
            && !last_byte;
    endsequence
    ld_edge_a: assert property (
        ld_cause_s |=> flags_q[0])
        else $error("low flag not set on edge");
    flag_sticky_a: assert property (
        flags_q[0] && !wr_st |=> flags_q[0])
        else $error("flag self cleared");
    one_ignored_a: assert property (
        !flags_q[1] && wr_st && !hw_set[1] |=> !flags_q[1])
        else $error("write one set flag");
    irq_level_a: assert property (
        lin_irq == |(flags_q & ie))
        else $error("irq does not follow enabled flags");
    no_new_req_a: assert property (
        any_flag && !wr_ic |=> $stable(int_priority_level_q[3]))
        else $error("request while flag set");
    abort_final_a: assert property (
        rx_err |=> in_final)
        else $error("error did not abort");
    no_csum_a: assert property (
        in_final && abort_q |=> !flags_q[3] || $past(flags_q[3]))
        else $error("checksum judged on abort");
    mirror_rd_a: assert property (
        acc && apb_req.paddr == lin_wake_pkg::MIRROR_OFS && !pready
        |=> prdata[3:0] == {$past(other_channel_low_flag),
                            $past(flags_q[0])})
        else $error("mirror wrong");
    length_step_a: assert property (
        more_bytes_s |=> state_q == lin_wake_pkg::RX_DATA
            && byte_cnt_q == $past(byte_cnt_q) + 4'h1)
        else $error("byte count did not step");
endmodule

// ### testbench/lin_node_model.sv
// Behavioural LIN bus node that drives the receive line of the block
module lin_node_model (
    input  wire logic core_clk,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus pull-up holds the line recessive (high) while idle
    initial line = 1'b1;

    // Drive one level for one bit time, starting just after an edge
    task automatic put(input logic v);
        line <= v;
        repeat (lin_wake_pkg::BIT_CYC) @(posedge core_clk);
    endtask

    // Send one byte: start bit, eight bits LSB first, stop, idle gap
    task automatic send_byte(input logic [7:0] b, input logic good_stop);
        put(1'b0);
        for (int i = 0; i < 8; i++) begin
            put(b[i]);
        end
        put(good_stop);
        put(1'b1);
    endtask
endmodule

// ### testbench/lin_wakeup_low_detect_test.sv
// Self-checking bench for the LIN wake and response receiver block
module lin_wakeup_low_detect_test;
    timeunit 1ns;
    timeprecision 1ps;

    // One register access: write flag, offset, data or expectation, error
    typedef struct packed {
        logic        wr;
        logic [7:0]  adr;
        logic [31:0] dat;
        logic        err;
    } row_t;

    logic                   core_clk = 1'b0;   // Core clock
    logic                   sys_rst  = 1'b1;   // Synchronous reset
    lin_wake_pkg::apb_req_t apb_req  = '0;     // Bus request
    logic [31:0]            prdata;            // Read data
    logic                   pready;            // Transfer done
    logic                   pslverr;           // Error response
    logic                   lin_line;          // Line from bus node
    logic [2:0]             other_flags = '0;  // Other channel flags
    logic                   rsp_start = 1'b0;  // Response start pulse
    logic                   lin_irq;           // Interrupt output
    logic                   low_detect_flag;   // Own low flag
    int                     miscompares = 0;   // Mismatch count
    int                     checks_done = 0;   // Comparison count
    logic [31:0]            q;                 // Last read data
    logic                   e;                 // Last error response
    // Ordinary accesses, the unmapped offsets among them
    row_t rows [8] = '{
        '{1'b1, 8'h04, 32'h0000_0002, 1'b0},
        '{1'b0, 8'h04, 32'h0000_0002, 1'b0},
        '{1'b1, 8'h00, 32'h0000_00f0, 1'b0},
        '{1'b0, 8'h00, 32'h0000_00f0, 1'b0},
        '{1'b0, 8'h08, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h10, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h18, 32'h0000_0000, 1'b1},
        '{1'b1, 8'h1c, 32'h0000_0000, 1'b1}
    };

    // Free-running 100 MHz clock
    always #5 core_clk = ~core_clk;

    lin_node_model node (.core_clk(core_clk), .line(lin_line));

    lin_wakeup_low_detect dut (
        .core_clk              (core_clk),
        .sys_rst               (sys_rst),
        .apb_req               (apb_req),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .lin_receive_input     (lin_line),
        .other_channel_low_flag(other_flags),
        .response_start        (rsp_start),
        .lin_irq               (lin_irq),
        .low_detect_flag       (low_detect_flag)
    );

    // Print the counts and the verdict, then stop
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compare a word
    task automatic chk32(input logic [31:0] got, input logic [31:0] x);
        checks_done++;
        if (got !== x) begin
            miscompares++;
            $display("wrong value at %0t: word %h not %h", $time, got, x);
        end
    endtask

    // Compare a single bit
    task automatic chk1(input logic got, input logic x);
        checks_done++;
        if (got !== x) begin
            miscompares++;
            $display("wrong value at %0t: bit %b not %b", $time, got, x);
        end
    endtask

    // One bus transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        e = pslverr;
        apb_req <= '0;
        if (n >= 40) begin
            miscompares++;
            print_verdict();
        end
    endtask

    // Register write and checked register read
    task automatic wt(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk32(q, x);
    endtask

    // One-cycle pulse that opens response reception
    task automatic start_rsp;
        rsp_start <= 1'b1;
        @(posedge core_clk);
        rsp_start <= 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk32(prdata, 32'h0);
        chk1(lin_irq, 1'b0);
        chk1(low_detect_flag, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].adr, rows[i].wr ? rows[i].dat : '0);
            chk1(e, rows[i].err);
            if (!rows[i].wr) chk32(q, rows[i].dat);
        end
        $display("test register rows done");
        // Reset in mid-run returns the registers to zero
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk1(lin_irq, 1'b0);
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        $display("test mid-run reset done");
        // Sleep preparation, then traffic on the bus wakes the core
        wt(8'h00, 32'h0000_0011);
        wt(8'h0c, 32'h0000_0000);
        wt(8'h08, 32'h0000_0000);
        wt(8'h0c, 32'h0000_0003);
        chk1(lin_irq, 1'b0);
        other_flags <= 3'b101;
        node.put(1'b0);
        node.put(1'b1);
        chk1(low_detect_flag, 1'b1);
        chk1(lin_irq, 1'b1);
        rd(8'h0c, 32'h0000_000b);
        rd(8'h10, 32'h0000_000b);
        $display("test wake done");
        // Two-byte response while the low flag still stands
        wt(8'h0c, 32'h0000_0003);
        wt(8'h04, 32'h0000_0002);
        wt(8'h00, 32'h0000_0031);
        start_rsp();
        node.send_byte(8'h00, 1'b1);
        rd(8'h08, 32'h0000_0001);
        node.send_byte(8'hff, 1'b1);
        rd(8'h08, 32'h0000_0003);
        rd(8'h14, 32'h0000_00ff);
        rd(8'h0c, 32'h0000_0003);
        chk1(lin_irq, 1'b1);
        $display("test response done");
        // Flags ignore ones and clear on zeros
        wt(8'h08, 32'h0000_000f);
        rd(8'h08, 32'h0000_0003);
        wt(8'h08, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        chk1(lin_irq, 1'b0);
        $display("test sticky flags done");
        // Enabling detection while the line is already low
        wt(8'h00, 32'h0000_0000);
        node.put(1'b0);
        chk1(low_detect_flag, 1'b0);
        wt(8'h00, 32'h0000_0001);
        rd(8'h08, 32'h0000_0001);
        node.put(1'b1);
        wt(8'h00, 32'h0000_0000);
        wt(8'h08, 32'h0000_0000);
        $display("test enable while low done");
        // Bad stop bit in the second of three bytes aborts the frame
        wt(8'h04, 32'h0000_0003);
        start_rsp();
        node.send_byte(8'h11, 1'b1);
        node.send_byte(8'h22, 1'b0);
        rd(8'h08, 32'h0000_0004);
        node.send_byte(8'h33, 1'b1);
        rd(8'h08, 32'h0000_0004);
        $display("test abort done");
        // Three bytes that sum to all ones, then one byte that does not
        wt(8'h08, 32'h0000_0000);
        start_rsp();
        node.send_byte(8'h01, 1'b1);
        node.send_byte(8'h02, 1'b1);
        node.send_byte(8'hfc, 1'b1);
        rd(8'h08, 32'h0000_0002);
        wt(8'h08, 32'h0000_0000);
        wt(8'h04, 32'h0000_0001);
        start_rsp();
        node.send_byte(8'h00, 1'b1);
        rd(8'h08, 32'h0000_000a);
        rd(8'h14, 32'h0000_0000);
        $display("test checksum done");
        print_verdict();
    end
endmodule
